// ---- design/iop_ports.sv ----
/*
  input ports 0-1 and output ports 2-7 of a 4-bit controller,
  reached over a classic wishbone slave with 32-bit data.
  assumes: one clock sys_clk, synchronous active-high rst;
  time base levels and the external transfer strobe come from
  logic on the same clock; input pins are asynchronous.
*/
// Implementation choice: the Wishbone slave port.
// Contract
// - read-only level register per input port
// - port 1 per-pin type, 0 resistor, 1 hi-z
// - one port 0 polarity bit, 0 down
// - port 1 polarity at bit 1, 0 down
// - bit 0 picks 128 Hz or 4 kHz sampling
// - per-pin interrupt enables, reset disabled
// - only enabled pins feed the interrupt
// - sample on sampling clock fall, raise request
// - flag set within one sampling period
// - interrupt delivered to vector 001EH
// - pull-down: fire on any-high or all-low
// - pull-up: fire on any-low or all-high; the code does so only with both ports pulled up, mixed polarity uses any-high
// - ports 2-3 data reset zero, second-state update
// - ports 4-7 data reset zero, second-state update
// - ports 2-3 four drive modes, reset CMOS
// - ports 4-7 four drive modes, reset CMOS
// - address bus select resets to zero
// - address out only during external transfer
// - mode 00 CMOS 01 N-OD 10 P-OD 11 hi-z
`include "iop_regs.svh"
`default_nettype none

module iop_ports
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire iop_pkg::iop_wb_req_type wb_req,
    output var  iop_pkg::iop_wb_rsp_type wb_rsp,
    input  wire logic [7:0]              in_pins,
    input  wire logic                    tb_128hz,
    input  wire logic                    tb_4khz,
    input  wire logic                    ext_xfer_active,
    input  wire logic [15:0]             ext_addr,
    output var  iop_pkg::iop_drive_type  pin_drive,
    output var  iop_pkg::iop_pull_type   pin_pull,
    output var  logic                    irq_request,
    output var  logic                    irq_flag,
    output var  logic [15:0]             irq_vector
);
    import iop_pkg::*;

    // whole block state in one record; s_nxt is its next value
    iop_state_type s_r;
    iop_state_type s_nxt;

    // drive enables of one pin from its mode and its data bit
    // open-drain modes leave the idle side off for an outside pull
    function automatic logic [1:0] drv_of
    (
        input logic [1:0] md,
        input logic       d
    );
        logic [1:0] r;
        r = 2'b00;
        if (md == `IOP_DRV_CMOS)
        begin
            r = {d, ~d};
        end
        else if (md == `IOP_DRV_NOD)
        begin
            r = {1'b0, ~d};
        end
        else if (md == `IOP_DRV_POD)
        begin
            r = {d, 1'b0};
        end
        else
        begin
            r = 2'b00;
        end
        return r;
    endfunction : drv_of

    // membership of the output data block, for read and write
    function automatic logic in_odata
    (
        input logic [5:0] idx
    );
        return (idx >= `IOP_IDX_ODATA0) && (idx <= `IOP_IDX_ODATA_LST);
    endfunction : in_odata

    // membership of the drive mode block, for read and write
    function automatic logic in_omode
    (
        input logic [5:0] idx
    );
        return (idx >= `IOP_IDX_OMODE0) && (idx <= `IOP_IDX_OMODE_LST);
    endfunction : in_omode

    // offset of an index inside a block that starts at base
    function automatic logic [5:0] slot_of
    (
        input logic [5:0] idx,
        input logic [5:0] base
    );
        return idx - base;
    endfunction : slot_of

    // read mux; unmapped and reserved bits read as zero
    // level reads lag the pins by the two synchroniser edges
    function automatic logic [3:0] rd_of
    (
        input iop_state_type s,
        input logic [5:0]    idx
    );
        logic [3:0] r;
        logic [5:0] k;
        r = `IOP_RST_NIB;
        k = 6'h00;
        if (idx == `IOP_IDX_IN0_LVL)
        begin
            r = s.sync2[3:0];
        end
        else if (idx == `IOP_IDX_IN1_LVL)
        begin
            r = s.sync2[7:4];
        end
        else if (idx == `IOP_IDX_IN0_TYPE)
        begin
            r = s.p0type;
        end
        else if (idx == `IOP_IDX_IN1_TYPE)
        begin
            r = s.p1type;
        end
        else if (idx == `IOP_IDX_IN1_PULL)
        begin
            r[`IOP_BIT_PUD]  = s.port1_pull_polarity;
            r[`IOP_BIT_RATE] = s.rate;
        end
        else if (idx == `IOP_IDX_IN0_PULL)
        begin
            r[`IOP_BIT_PUD] = s.port0_pull_polarity;
        end
        else if (idx == `IOP_IDX_IE0)
        begin
            r = s.ie0;
        end
        else if (idx == `IOP_IDX_IE1)
        begin
            r = s.ie1;
        end
        else if (idx == `IOP_IDX_STATUS)
        begin
            r[`IOP_BIT_FLAG] = s.flag;
        end
        else if (in_odata(idx))
        begin
            k = slot_of(idx, `IOP_IDX_ODATA0);
            r = s.odata[k[2:0]];
        end
        else if (in_omode(idx))
        begin
            k = slot_of(idx, `IOP_IDX_OMODE0);
            r = k[0] ? s.omode[k[3:1]][7:4] : s.omode[k[3:1]][3:0];
        end
        else if (idx == `IOP_IDX_ABUS)
        begin
            r = s.abus;
        end
        else
        begin
            r = `IOP_RST_NIB;
        end
        return r;
    endfunction : rd_of

    // next state of the whole block
    // every temporary is given a value first, so nothing latches
    always_comb
    begin
        logic [5:0] idx;
        logic [5:0] k;
        logic [3:0] wd;
        logic       tb_cur;
        logic       fall;
        logic       lvl;
        logic [7:0] act;
        logic [3:0] nib;
        logic [1:0] dv;
        idx    = wb_req.adr[`IOP_ADR_IDX_HI:`IOP_ADR_IDX_LO];
        k      = 6'h00;
        wd     = wb_req.dat[3:0];
        tb_cur = 1'b0;
        fall   = 1'b0;
        lvl    = 1'b0;
        act    = 8'h00;
        nib    = `IOP_RST_NIB;
        dv     = 2'b00;
        s_nxt  = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.req = 1'b0;

        // two-flop synchroniser on the input pins
        s_nxt.sync1 = in_pins;
        s_nxt.sync2 = s_r.sync1;

        // bus: one wait state, ack drops the cycle after it rose
        // a master holding stb past ack gets a fresh ack every other
        // cycle, so back-to-back cycles need one idle cycle between
        if (wb_req.cyc && wb_req.stb && !s_r.ack)
        begin
            s_nxt.ack  = 1'b1;
            s_nxt.rdat = rd_of(s_r, idx);
            if (wb_req.we && wb_req.sel[0])
            begin
                if (idx == `IOP_IDX_IN0_TYPE)
                begin
                    s_nxt.p0type = wd;
                end
                else if (idx == `IOP_IDX_IN1_TYPE)
                begin
                    s_nxt.p1type = wd;
                end
                else if (idx == `IOP_IDX_IN1_PULL)
                begin
                    s_nxt.port1_pull_polarity = wd[`IOP_BIT_PUD];
                    s_nxt.rate  = wd[`IOP_BIT_RATE];
                end
                else if (idx == `IOP_IDX_IN0_PULL)
                begin
                    s_nxt.port0_pull_polarity = wd[`IOP_BIT_PUD];
                end
                else if (idx == `IOP_IDX_IE0)
                begin
                    s_nxt.ie0 = wd;
                end
                else if (idx == `IOP_IDX_IE1)
                begin
                    s_nxt.ie1 = wd;
                end
                else if (idx == `IOP_IDX_STATUS)
                begin
                    // write one to clear; a same-cycle set below wins
                    if (wd[`IOP_BIT_FLAG])
                    begin
                        s_nxt.flag = 1'b0;
                    end
                end
                else if (in_odata(idx))
                begin
                    k = slot_of(idx, `IOP_IDX_ODATA0);
                    s_nxt.odata[k[2:0]] = wd;
                end
                else if (in_omode(idx))
                begin
                    k = slot_of(idx, `IOP_IDX_OMODE0);
                    if (k[0])
                    begin
                        s_nxt.omode[k[3:1]][7:4] = wd;
                    end
                    else
                    begin
                        s_nxt.omode[k[3:1]][3:0] = wd;
                    end
                end
                else if (idx == `IOP_IDX_ABUS)
                begin
                    s_nxt.abus = wd;
                end
                else
                begin
                    s_nxt.abus = s_r.abus; // unmapped: write ignored
                end
            end
        end

        // sampling clock choice and its falling edge
        // a rate switch can pair the old source's high with the new
        // source's low and look like a fall; not filtered, so software
        // clears the flag after changing the rate
        tb_cur = s_r.rate ? tb_4khz : tb_128hz;
        s_nxt.tb_prev = tb_cur;
        fall = s_r.tb_prev & ~tb_cur;

        // combined level: any-high with pull-down, all-high with
        // pull-up; disabled pins sit at the neutral value
        // mixed polarity falls back to the any-high form
        act = {s_r.ie1, s_r.ie0};
        if (s_r.port0_pull_polarity && s_r.port1_pull_polarity)
        begin
            lvl = &(s_r.sync2 | ~act);
        end
        else
        begin
            lvl = |(s_r.sync2 & act);
        end

        // first sample only primes, so reset makes no false event
        // the set sits after the bus clear above, so an event in the
        // same cycle as a write-one-to-clear is never lost
        if (fall)
        begin
            s_nxt.samp   = lvl;
            s_nxt.primed = 1'b1;
            if (s_r.primed && (lvl != s_r.samp))
            begin
                s_nxt.req  = 1'b1;
                s_nxt.flag = 1'b1;
            end
        end

        // pins follow the registers one edge late, the second-state edge
        // ext_xfer_active and ext_addr come from the same clock, need no
        // synchroniser, and reach the pins one edge late as well
        for (int i = 0; i < 6; i++)
        begin
            nib = s_r.odata[i];
            if (i >= 2)
            begin
                // address nibble i-2 replaces data only in transfers
                if (s_r.abus[i - 2] && ext_xfer_active)
                begin
                    nib = ext_addr[(i - 2) * 4 +: 4];
                end
            end
            for (int b = 0; b < 4; b++)
            begin
                dv = drv_of(s_r.omode[i][b * 2 +: 2], nib[b]);
                s_nxt.hi[i * 4 + b] = dv[1];
                s_nxt.lo[i * 4 + b] = dv[0];
            end
        end

        // resistor controls: type bit 0 enables, polarity per port
        // a hi-z type bit turns the resistor off and leaves the pin open
        s_nxt.pen = ~{s_r.p1type, s_r.p0type};
        s_nxt.pup = {{4{s_r.port1_pull_polarity}}, {4{s_r.port0_pull_polarity}}};
    end

    // single state register; every control field resets to zero
    // constants only in reset; on the first edge after release the
    // pins settle to cmos low and the resistors switch on
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    // read data above the nibble is tied low; one nibble is stored
    assign wb_rsp.ack    = s_r.ack;
    assign wb_rsp.dat    = {28'h000_0000, s_r.rdat};
    assign pin_drive.hi  = s_r.hi;
    assign pin_drive.lo  = s_r.lo;
    assign pin_pull.en   = s_r.pen;
    assign pin_pull.up   = s_r.pup;
    assign irq_request   = s_r.req;
    assign irq_flag      = s_r.flag;
    // fixed vector for the interrupt controller
    // a constant, so no register is spent on it
    assign irq_vector    = `IOP_IRQ_VECTOR;

endmodule : iop_ports

`default_nettype wire

// ---- design/iop_regs.svh ----
/*
  register indices, field positions, encodings and reset values
  for the input/output port block.
  assumes: included by bare name, byte address = 4 * index.
*/
`ifndef IOP_REGS_SVH
`define IOP_REGS_SVH

// register indices (byte address is index times four)
`define IOP_IDX_IN0_LVL   6'h10
`define IOP_IDX_IN1_LVL   6'h11
`define IOP_IDX_IN0_TYPE  6'h12
`define IOP_IDX_IN1_TYPE  6'h13
`define IOP_IDX_IN1_PULL  6'h14
`define IOP_IDX_IN0_PULL  6'h15
`define IOP_IDX_IE0       6'h16
`define IOP_IDX_IE1       6'h17
`define IOP_IDX_STATUS    6'h18
`define IOP_IDX_ODATA0    6'h20
`define IOP_IDX_ODATA_LST 6'h25
`define IOP_IDX_OMODE0    6'h28
`define IOP_IDX_OMODE_LST 6'h33
`define IOP_IDX_ABUS      6'h34

// field positions
`define IOP_BIT_RATE      0
`define IOP_BIT_PUD       1
`define IOP_BIT_FLAG      0
`define IOP_ADR_IDX_HI    7
`define IOP_ADR_IDX_LO    2

// output drive mode encodings, two bits per pin
`define IOP_DRV_CMOS      2'h0
`define IOP_DRV_NOD       2'h1
`define IOP_DRV_POD       2'h2
`define IOP_DRV_HIZ       2'h3

// reset values and constants
`define IOP_RST_NIB       4'h0
`define IOP_RST_BIT       1'b0
`define IOP_IRQ_VECTOR    16'h001e

`endif

// ---- design/iop_pkg.sv ----
/*
  types of the input/output port block: bus carriers, pin
  carriers and the block's state record.
  assumes: compiled before the block, iop_regs.svh alongside.
*/
`default_nettype none

package iop_pkg;

    // classic wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } iop_wb_req_type;

    // slave answer
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } iop_wb_rsp_type;

    // drive-high and drive-low enables, ports 2..7, four pins each
    typedef struct packed {
        logic [23:0] hi;
        logic [23:0] lo;
    } iop_drive_type;

    // resistor controls, ports 0 and 1
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] up;
    } iop_pull_type;

    // all state of the block
    typedef struct packed {
        logic            ack;
        logic [3:0]      rdat;
        logic [7:0]      sync1;
        logic [7:0]      sync2;
        logic [3:0]      p0type;
        logic [3:0]      p1type;
        logic            port0_pull_polarity;
        logic            port1_pull_polarity;
        logic            rate;
        logic [3:0]      ie0;
        logic [3:0]      ie1;
        logic            flag;
        logic            req;
        logic            samp;
        logic            primed;
        logic            tb_prev;
        logic [5:0][3:0] odata;
        logic [5:0][7:0] omode;
        logic [3:0]      abus;
        logic [23:0]     hi;
        logic [23:0]     lo;
        logic [7:0]      pen;
        logic [7:0]      pup;
    } iop_state_type;

endpackage : iop_pkg

`default_nettype wire

// ---- test/iop_ports_asserts.sv ----
/* concurrent checks on the port block's bus, pins and interrupt.
   assumes: bound onto iop_ports, one clock, sync high reset. */
`default_nettype none
module iop_ports_asserts
(
    input wire logic                    sys_clk,
    input wire logic                    rst,
    input wire iop_pkg::iop_wb_req_type wb_req,
    input wire iop_pkg::iop_wb_rsp_type wb_rsp,
    input wire logic [7:0]              in_pins,
    input wire logic                    tb_128hz,
    input wire logic                    tb_4khz,
    input wire logic                    ext_xfer_active,
    input wire logic [15:0]             ext_addr,
    input wire iop_pkg::iop_drive_type  pin_drive,
    input wire iop_pkg::iop_pull_type   pin_pull,
    input wire logic                    irq_request,
    input wire logic                    irq_flag,
    input wire logic [15:0]             irq_vector
);
    timeunit 1ns;
    timeprecision 1ps;
    import iop_pkg::*;

    default clocking dck @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // a request trails a time base fall by two edges; a rate switch
    // can pair one source's high with the other's low
    sequence s_base_fell;
        ($past(tb_128hz, 2) || $past(tb_4khz, 2)) &&
        (!$past(tb_128hz) || !$past(tb_4khz));
    endsequence

    AST_VECTOR: assert property (irq_vector == 16'h001e)
        else $error("interrupt vector wrong");
    AST_REQ_ON_FALL: assert property (irq_request |-> s_base_fell)
        else $error("request without sampling fall");
    AST_REQ_PULSE: assert property (irq_request |=> !irq_request)
        else $error("request longer than one cycle");
    AST_REQ_FLAG: assert property (irq_request |-> irq_flag)
        else $error("request without flag");
    AST_FLAG_CAUSE: assert property ($rose(irq_flag) |-> irq_request)
        else $error("flag set without request");
    AST_FLAG_STICKY: assert property
        (irq_flag && !(wb_req.stb && wb_req.we) |=> irq_flag)
        else $error("flag dropped without a write");
    AST_DRIVE_EXCL: assert property
        ((pin_drive.hi & pin_drive.lo) == 24'h00_0000)
        else $error("pin driven high and low");
    AST_PULL_RESET: assert property ($fell(rst) |=>
        pin_pull.en == 8'hff && pin_pull.up == 8'h00)
        else $error("pull reset state wrong");
    AST_DRIVE_RESET: assert property ($fell(rst) |=>
        pin_drive.lo == 24'hff_ffff && pin_drive.hi == 24'h00_0000)
        else $error("drive reset state wrong");
    AST_ACK_PULSE: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_rsp.ack) |-> $past(wb_req.stb))
        else $error("ack without request");
endmodule : iop_ports_asserts

bind iop_ports iop_ports_asserts iop_ports_asserts_i (.sys_clk, .rst,
    .wb_req, .wb_rsp, .in_pins, .tb_128hz, .tb_4khz, .ext_xfer_active,
    .ext_addr, .pin_drive, .pin_pull, .irq_request, .irq_flag,
    .irq_vector);

`default_nettype wire

// ---- test/iop_pin_model.sv ----
/* parts outside the input pins: drivers, resistors, open lines.
   assumes: bench picks which pins are driven and to what level. */
`default_nettype none
module iop_pin_model
(
    input  wire logic                  sys_clk,
    input  wire iop_pkg::iop_pull_type pin_pull,
    input  wire logic [7:0]            ext_lvl,
    input  wire logic [7:0]            ext_en,
    output var  logic [7:0]            in_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import iop_pkg::*;

    logic [7:0] wobble_r = 8'h5a;

    // an open input wanders, so a stale level never passes for real
    always @(posedge sys_clk)
        wobble_r <= ~wobble_r;

    // a driver wins, then the resistor, then the wandering line
    always_comb
        for (int i = 0; i < 8; i++)
            in_pins[i] = ext_en[i] ? ext_lvl[i] :
                pin_pull.en[i] ? pin_pull.up[i] : wobble_r[i];
endmodule : iop_pin_model

`default_nettype wire

// ---- test/tb_iop_ports.sv ----
/* bench for iop_ports: reset values, registers, drive modes,
   address bus and input-change interrupt.
   assumes: package, pin model and checker compiled before it. */
`default_nettype none
module tb_iop_ports;
    timeunit 1ns;
    timeprecision 1ps;
    import iop_pkg::*;

    logic           sys_clk = 1'b0;
    logic           rst = 1'b1;
    iop_wb_req_type wb_req = '0;
    iop_wb_rsp_type wb_rsp;
    logic [7:0]     ext_lvl = 8'h00;
    logic [7:0]     ext_en = 8'hff;
    logic [7:0]     in_pins;
    logic           tb_128hz = 1'b0;
    logic           tb_4khz = 1'b0;
    logic           ext_xfer_active = 1'b0;
    logic [15:0]    ext_addr = 16'h0000;
    iop_drive_type  pin_drive;
    iop_pull_type   pin_pull;
    logic           irq_request;
    logic           irq_flag;
    logic [15:0]    irq_vector;
    int             tick = 0;
    int             n_fail = 0;
    int             num_checks = 0;

    // 50 MHz system clock
    always #10 sys_clk = ~sys_clk;

    // time base scaled to 200 and 40 cycles to keep the run short
    always @(posedge sys_clk)
    begin
        tick <= tick + 1;
        tb_128hz <= (tick % 200) < 100;
        tb_4khz <= (tick % 40) < 20;
    end

    iop_ports iop_ports_i (.sys_clk, .rst, .wb_req, .wb_rsp, .in_pins,
        .tb_128hz, .tb_4khz, .ext_xfer_active, .ext_addr, .pin_drive,
        .pin_pull, .irq_request, .irq_flag, .irq_vector);
    iop_pin_model iop_pin_model_i (.sys_clk, .pin_pull, .ext_lvl,
        .ext_en, .in_pins);

    task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one classic cycle, held until ack, entered just after an edge
    task automatic wb(logic we, logic [5:0] a, logic [3:0] d,
                      output logic [3:0] q);
        wb_req <= {1'b1, 1'b1, we, a, 2'b00, 4'h1, 28'h0, d};
        do
            @(posedge sys_clk);
        while (wb_rsp.ack !== 1'b1);
        q = wb_rsp.dat[3:0];
        wb_req <= '0;
        @(posedge sys_clk);
    endtask : wb

    task automatic wr(logic [5:0] a, logic [3:0] d);
        logic [3:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(string nm, logic [5:0] a, logic [3:0] e);
        logic [3:0] q;
        wb(1'b0, a, 4'h0, q);
        chk(nm, 24'(e), 24'(q));
    endtask : rdc

    task automatic t_reset();
        for (int i = 'h12; i <= 'h34; i++)
            rdc("reset value", 6'(i), 4'h0);
        chk("drive lo", 24'hff_ffff, pin_drive.lo);
    endtask : t_reset

    task automatic t_regs();
        wr(6'h16, 4'ha);
        rdc("irq enable", 6'h16, 4'ha);
        wr(6'h16, 4'h0);
        wr(6'h3f, 4'hf);
        rdc("unmapped", 6'h3f, 4'h0);
        wr(6'h10, 4'hf);
        rdc("port0 level", 6'h10, 4'h0);
        ext_lvl <= 8'h3c;
        repeat (3) @(posedge sys_clk);
        rdc("port0 level", 6'h10, 4'hc);
        rdc("port1 level", 6'h11, 4'h3);
        wr(6'h13, 4'h5);
        wr(6'h15, 4'h2);
        wr(6'h14, 4'h2);
        chk("pull en", 24'h00_00af, 24'(pin_pull.en));
        chk("pull up", 24'h00_00af, 24'(pin_pull.up & pin_pull.en));
        wr(6'h13, 4'h0);
        // release port 1 so only its pull-ups set the level
        ext_en <= 8'h0f;
        repeat (3) @(posedge sys_clk);
        rdc("port1 pulled up", 6'h11, 4'hf);
        ext_en <= 8'hff;
    endtask : t_regs

    task automatic t_drive();
        logic [1:0] m;
        logic [3:0] e;
        logic [7:0] g;
        wr(6'h20, 4'h1);
        for (int i = 0; i < 4; i++)
        begin
            m = 2'(i);
            e = {1'b0, ~m[0], ~m[1], 1'b0};
            wr(6'h28, {m, m});
            g = 8'({pin_drive.hi[1:0], pin_drive.lo[1:0]});
            chk("port2 drive", 24'(e), 24'(g));
        end
        wr(6'h25, 4'h9);
        g = {pin_drive.hi[23:20], pin_drive.lo[23:20]};
        chk("port7 drive", 24'h00_0096, 24'(g));
        ext_addr <= 16'h005a;
        wr(6'h34, 4'h1);
        wr(6'h22, 4'h3);
        ext_xfer_active <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("addr out", 24'h00_000a, 24'(pin_drive.hi[15:8]));
        ext_xfer_active <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("data out", 24'h00_0003, 24'(pin_drive.hi[15:8]));
    endtask : t_drive

    // waits a bounded span for the flag, then clears it
    task automatic irq_wait(string nm, logic e, int lim);
        int n;
        n = 0;
        while (irq_flag !== 1'b1 && n < lim)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk(nm, 24'(e), 24'(irq_flag));
        wr(6'h18, 4'h1);
    endtask : irq_wait

    task automatic t_irq();
        wr(6'h15, 4'h0);
        wr(6'h14, 4'h0);
        ext_lvl <= 8'hff;
        wr(6'h16, 4'hf);
        wr(6'h17, 4'hf);
        repeat (210) @(posedge sys_clk);
        wr(6'h18, 4'h1);
        ext_lvl <= 8'hfe;
        irq_wait("down one low", 1'b0, 205);
        ext_lvl <= 8'h00;
        irq_wait("down all low", 1'b1, 205);
        ext_lvl <= 8'h10;
        irq_wait("down one high", 1'b1, 205);
        ext_lvl <= 8'h00;
        irq_wait("down low again", 1'b1, 205);
        wr(6'h17, 4'he);
        ext_lvl <= 8'h10;
        irq_wait("masked pin", 1'b0, 205);
        wr(6'h17, 4'hf);
        wr(6'h15, 4'h2);
        wr(6'h14, 4'h3);
        ext_lvl <= 8'hff;
        repeat (210) @(posedge sys_clk);
        wr(6'h18, 4'h1);
        ext_lvl <= 8'hef;
        irq_wait("up one low", 1'b1, 45);
        ext_lvl <= 8'h7f;
        irq_wait("up one high", 1'b0, 45);
        ext_lvl <= 8'hff;
        irq_wait("up all high", 1'b1, 45);
    endtask : t_irq

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // main sequence after eight cycles of reset
    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_regs();
        t_drive();
        t_irq();
        tally_and_finish();
    end

    // hang guard, about three and a half times the expected run
    initial
    begin
        #120000;
        n_fail++;
        tally_and_finish();
    end
endmodule : tb_iop_ports

`default_nettype wire
